// ### design/vtr_consts.svh
// Register indices, field positions and reset values of the VLAN table reader
`ifndef VTR_CONSTS_SVH
`define VTR_CONSTS_SVH

// Word indices; the byte address is four times the index
`define VTR_IDX_CMD        30'h0000180c
`define VTR_IDX_WRVAL      30'h0000180d
`define VTR_IDX_RDVAL      30'h0000180e
`define VTR_IDX_STAT       30'h00001810
`define VTR_IDX_ADMIT      30'h00001841
`define VTR_IDX_EGTYPE     30'h00001842

// Command register fields
`define VTR_CMD_IDX_MSB    4
`define VTR_CMD_PSEL_BIT   5
`define VTR_CMD_READ_BIT   6
`define VTR_CMD_W          7

// Table word fields
`define VTR_ENTRY_W        18
`define VTR_VID_MSB        11
`define VTR_PRI_LSB        12
`define VTR_PRI_MSB        14
`define VTR_PDEF_W         15
`define VTR_UTG0_BIT       12
`define VTR_MBR0_BIT       13
`define VTR_PORTS          3
`define VTR_VLAN_ENTRIES   16

// Reset values
`define VTR_RDVAL_RESET    18'h00000
`define VTR_PDEF_RESET     15'h0000
`define VTR_CMD_RESET      7'h00
`define VTR_NULL_VID       12'h000

`endif

// ### design/vtr_pkg.sv
// Types shared by the VLAN table reader and its table memory
package vtr_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ISSUE   = 2'b01,
    ST_CAPTURE = 2'b11
  } vtr_state_t;

  typedef logic [17:0] vtr_entry_t;
  typedef logic [11:0] vtr_vid_t;
  typedef logic [2:0]  vtr_pri_t;
  typedef logic [3:0]  vtr_idx_t;

endpackage : vtr_pkg

// ### design/vtr_mem_if.sv
// Connection between the table reader and the VLAN table memory
`timescale 1ns/1ps
interface vtr_mem_if;
  logic                wrEn;
  vtr_pkg::vtr_idx_t   wrIdx;
  vtr_pkg::vtr_entry_t wrData;
  logic                rdEn;
  vtr_pkg::vtr_idx_t   rdIdx;
  vtr_pkg::vtr_entry_t rdData;
  vtr_pkg::vtr_vid_t   lkVid;
  logic                lkHit;
  vtr_pkg::vtr_entry_t lkEntry;

  modport ctrl (
    output wrEn,
    output wrIdx,
    output wrData,
    output rdEn,
    output rdIdx,
    input  rdData,
    output lkVid,
    input  lkHit,
    input  lkEntry
  );

  modport mem (
    input  wrEn,
    input  wrIdx,
    input  wrData,
    input  rdEn,
    input  rdIdx,
    output rdData,
    input  lkVid,
    output lkHit,
    output lkEntry
  );
endinterface : vtr_mem_if

// ### design/vtr_vlan_mem.sv
// VLAN table storage with a software port and a VID lookup port
`timescale 1ns/1ps
`include "vtr_consts.svh"
module vtr_vlan_mem (
  input wire logic clk,
  input wire logic rst_n,
  vtr_mem_if.mem   mp
);

  vtr_pkg::vtr_entry_t             entry_q [`VTR_VLAN_ENTRIES];
  logic [`VTR_VLAN_ENTRIES-1:0]    match;
  vtr_pkg::vtr_entry_t             rdData_q;
  logic                            lkHit_q;
  vtr_pkg::vtr_entry_t             lkEntry_q;
  logic                            anyHit;
  vtr_pkg::vtr_entry_t             firstHit;

  // Entries cleared at reset carry the null VID and so never match
  genvar g;
  generate
    for (g = 0; g < `VTR_VLAN_ENTRIES; g++) begin : gEntry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          entry_q[g] <= '0;
        end else if (mp.wrEn && mp.wrIdx == 4'(g)) begin
          entry_q[g] <= mp.wrData;
        end
      end
      assign match[g] = (entry_q[g][`VTR_VID_MSB:0] == mp.lkVid) &&
                        (entry_q[g][`VTR_VID_MSB:0] != `VTR_NULL_VID); // RULE11
    end
  endgenerate

  // Lowest matching index wins if software made duplicate entries
  always_comb begin
    anyHit   = 1'b0;
    firstHit = '0;
    for (int i = `VTR_VLAN_ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        anyHit   = 1'b1;
        firstHit = entry_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q  <= '0;
      lkHit_q   <= 1'b0;
      lkEntry_q <= '0;
    end else begin
      if (mp.rdEn) begin
        rdData_q <= entry_q[mp.rdIdx];
      end
      lkHit_q   <= anyHit;
      lkEntry_q <= firstHit;
    end
  end

  assign mp.rdData  = rdData_q;
  assign mp.lkHit   = lkHit_q;
  assign mp.lkEntry = lkEntry_q;

endmodule : vtr_vlan_mem

// ### design/vtr_vlan_table_read_data.sv
// VLAN and port default tables with their read-data register on AHB-Lite
// Function
// RULE1 - Port table mode: default VID in 11:0, priority in 14:12, rest zero.
// RULE2 - Untagged or null-VID frames take the port's default VID and priority.
// RULE3 - All three port defaults are zero after reset.
// RULE4 - VLAN table mode: bits 17:0 hold member/untag flags then the VID.
// RULE5 - Member port accepts matching frames and joins the broadcast domain.
// RULE6 - Non-member drops matching frames unless admit-non-member is set.
// RULE7 - Untag bit strips tags of matching frames leaving by hybrid ports.
// RULE8 - Port 1 flags at 15:14, port 0 at 13:12, like port 2 at 17:16.
// RULE9 - VLAN table mode returns the entry's 12-bit VID in bits 11:0.
// RULE10 - Read-data register is read-only, 31:18 zero, resets to zero.
// RULE11 - VID zero marks a disabled entry and never matches.
// RULE12 - Pending bit stays set during a command, clears itself when done.
// RULE13 - Read-data loads only when a read command completes.
`timescale 1ns/1ps
`include "vtr_consts.svh"
module vtr_vlan_table_read_data (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  // Ingress frame classification request
  input  wire logic        frmValid,
  input  wire logic [1:0]  frmPort,
  input  wire logic        frmTagged,
  input  wire logic [11:0] frmVid,
  input  wire logic [2:0]  frmPri,
  // Classification result, two cycles later
  output      logic        fwdValid,
  output      logic [11:0] fwdVid,
  output      logic [2:0]  fwdPri,
  output      logic        fwdDrop,
  output      logic [2:0]  fwdEgressMask,
  output      logic [2:0]  fwdUntagMask
);

  vtr_mem_if memBus ();

  vtr_vlan_mem uMem (
    .clk   (clk),
    .rst_n (rst_n),
    .mp    (memBus.mem)
  );

  // ---------------- Register storage ----------------
  logic [`VTR_CMD_W-1:0]    cmd_q;
  logic [`VTR_ENTRY_W-1:0]  wrVal_q;
  logic [`VTR_ENTRY_W-1:0]  rdVal_q;
  logic [`VTR_PORTS-1:0]    admit_q;
  logic [`VTR_PORTS-1:0]    egType_q;
  logic [`VTR_PDEF_W-1:0]   pdef_q [`VTR_PORTS];
  vtr_pkg::vtr_state_t      state_q;
  vtr_pkg::vtr_state_t      state_d;

  // Data-phase bookkeeping for writes
  logic                     wrCmd_q;
  logic                     wrWrVal_q;
  logic                     wrAdmit_q;
  logic                     wrEgType_q;

  logic [31:0]              hrdata_q;
  logic                     hreadyout_q;
  logic                     hresp_q;

  // ---------------- Address decode ----------------
  wire        addrTaken = hsel && htrans[1] && hready;
  wire [29:0] wordAddr  = haddr[31:2];
  wire        selCmd    = (wordAddr == `VTR_IDX_CMD);
  wire        selWrVal  = (wordAddr == `VTR_IDX_WRVAL);
  wire        selRdVal  = (wordAddr == `VTR_IDX_RDVAL);
  wire        selStat   = (wordAddr == `VTR_IDX_STAT);
  wire        selAdmit  = (wordAddr == `VTR_IDX_ADMIT);
  wire        selEgType = (wordAddr == `VTR_IDX_EGTYPE);
  wire        rdTaken   = addrTaken && !hwrite;
  wire        wrTaken   = addrTaken && hwrite;

  // ---------------- Command decode ----------------
  wire [4:0]  cmdIdx     = cmd_q[`VTR_CMD_IDX_MSB:0];
  wire        cmdPortSel = cmd_q[`VTR_CMD_PSEL_BIT];
  wire        cmdRead    = cmd_q[`VTR_CMD_READ_BIT];
  wire        stIdle     = (state_q == vtr_pkg::ST_IDLE);
  wire        stIssue    = (state_q == vtr_pkg::ST_ISSUE);
  wire        stCapture  = (state_q == vtr_pkg::ST_CAPTURE);
  wire        opPending  = !stIdle; // RULE12
  // A command written while one is pending is ignored
  wire        cmdStart   = wrCmd_q && stIdle;
  wire        vlanIdxOk  = (cmdIdx < 5'd16);
  wire        portIdxOk  = (cmdIdx < 5'd3);
  wire        pdefWrite  = stIssue && cmdPortSel && !cmdRead && portIdxOk;

  // Port table word: VID 11:0, priority 14:12, upper bits zero
  wire [`VTR_PDEF_W-1:0] pdefSel =
    !portIdxOk        ? '0 :
    (cmdIdx == 5'd0)  ? pdef_q[0] :
    (cmdIdx == 5'd1)  ? pdef_q[1] : pdef_q[2];
  wire [`VTR_ENTRY_W-1:0] portWord = {3'h0, pdefSel}; // RULE1
  // VLAN entry word is passed through in its stored layout
  wire [`VTR_ENTRY_W-1:0] vlanWord =
    vlanIdxOk ? memBus.rdData : '0; // RULE4 RULE8 RULE9
  wire [`VTR_ENTRY_W-1:0] capWord = cmdPortSel ? portWord : vlanWord;
  wire                    rdLoad  = stCapture && cmdRead; // RULE13

  assign memBus.wrEn   = stIssue && !cmdPortSel && !cmdRead && vlanIdxOk;
  assign memBus.wrIdx  = cmdIdx[3:0];
  assign memBus.wrData = wrVal_q;
  assign memBus.rdEn   = stIssue && !cmdPortSel && cmdRead;
  assign memBus.rdIdx  = cmdIdx[3:0];

  // ---------------- Command sequencer ----------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      vtr_pkg::ST_IDLE:    if (cmdStart) state_d = vtr_pkg::ST_ISSUE;
      vtr_pkg::ST_ISSUE:   state_d = vtr_pkg::ST_CAPTURE;
      vtr_pkg::ST_CAPTURE: state_d = vtr_pkg::ST_IDLE;
      default:             state_d = vtr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= vtr_pkg::ST_IDLE;
    end else begin
      state_q <= state_d; // RULE12
    end
  end

  // ---------------- Register writes ----------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrCmd_q    <= 1'b0;
      wrWrVal_q  <= 1'b0;
      wrAdmit_q  <= 1'b0;
      wrEgType_q <= 1'b0;
    end else begin
      wrCmd_q    <= wrTaken && selCmd;
      wrWrVal_q  <= wrTaken && selWrVal;
      wrAdmit_q  <= wrTaken && selAdmit;
      wrEgType_q <= wrTaken && selEgType;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= `VTR_CMD_RESET;
    end else if (cmdStart) begin
      cmd_q <= hwdata[`VTR_CMD_W-1:0];
    end
  end

  // Write data is frozen while a command uses it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrVal_q <= '0;
    end else if (wrWrVal_q && stIdle) begin
      wrVal_q <= hwdata[`VTR_ENTRY_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      admit_q  <= '0;
      egType_q <= '0;
    end else begin
      if (wrAdmit_q) admit_q <= hwdata[`VTR_PORTS-1:0];
      if (wrEgType_q) egType_q <= hwdata[`VTR_PORTS-1:0];
    end
  end

  // Bus writes to the read-data register have no effect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdVal_q <= `VTR_RDVAL_RESET; // RULE10
    end else if (rdLoad) begin
      rdVal_q <= capWord; // RULE13
    end
  end

  genvar p;
  generate
    for (p = 0; p < `VTR_PORTS; p++) begin : gPdef
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pdef_q[p] <= `VTR_PDEF_RESET; // RULE3
        end else if (pdefWrite && cmdIdx == 5'(p)) begin
          pdef_q[p] <= wrVal_q[`VTR_PDEF_W-1:0];
        end
      end
    end
  endgenerate

  // ---------------- Bus read path ----------------
  // Read data are picked in the address phase; a read right after a write
  // to the same register returns the value before that write.
  wire [31:0] rdMux =
    selCmd    ? {25'h0, cmd_q} :
    selWrVal  ? {14'h0, wrVal_q} :
    selRdVal  ? {14'h0, rdVal_q} : // RULE10
    selStat   ? {31'h0, opPending} : // RULE12
    selAdmit  ? {29'h0, admit_q} :
    selEgType ? {29'h0, egType_q} : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q    <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      if (rdTaken) hrdata_q <= rdMux;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  // ---------------- Frame classification ----------------
  wire                    inPortOk  = (frmPort != 2'd3);
  wire [`VTR_PDEF_W-1:0]  inDef     =
    !inPortOk          ? '0 :
    (frmPort == 2'd0)  ? pdef_q[0] :
    (frmPort == 2'd1)  ? pdef_q[1] : pdef_q[2];
  wire                    useDef    = !frmTagged || frmVid == `VTR_NULL_VID;
  wire [11:0]             effVid    =
    useDef ? inDef[`VTR_VID_MSB:0] : frmVid; // RULE2
  wire [2:0]              effPri    =
    useDef ? inDef[`VTR_PRI_MSB:`VTR_PRI_LSB] : frmPri; // RULE2

  assign memBus.lkVid = effVid;

  logic        s1Valid_q;
  logic [1:0]  s1Port_q;
  logic        s1PortOk_q;
  logic [11:0] s1Vid_q;
  logic [2:0]  s1Pri_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Valid_q  <= 1'b0;
      s1Port_q   <= 2'h0;
      s1PortOk_q <= 1'b0;
      s1Vid_q    <= 12'h0;
      s1Pri_q    <= 3'h0;
    end else begin
      s1Valid_q  <= frmValid;
      s1Port_q   <= frmPort;
      s1PortOk_q <= inPortOk;
      s1Vid_q    <= effVid;
      s1Pri_q    <= effPri;
    end
  end

  wire [`VTR_PORTS-1:0] mbrBits;
  wire [`VTR_PORTS-1:0] utgBits;
  generate
    for (p = 0; p < `VTR_PORTS; p++) begin : gFlags
      assign mbrBits[p] = memBus.lkEntry[`VTR_MBR0_BIT + 2*p]; // RULE8
      assign utgBits[p] = memBus.lkEntry[`VTR_UTG0_BIT + 2*p]; // RULE8
    end
  endgenerate

  wire [1:0] pIdx      = s1PortOk_q ? s1Port_q : 2'd0;
  wire       isMember  = memBus.lkHit && mbrBits[pIdx]; // RULE5
  wire       admitNon  = admit_q[pIdx];
  wire       dropFrm   = !s1PortOk_q || (!isMember && !admitNon); // RULE6
  wire [2:0] egMask    = memBus.lkHit ? mbrBits : 3'h0; // RULE5 RULE6
  wire       stripFrm  = memBus.lkHit && utgBits[pIdx]; // RULE7
  wire [2:0] untagMask = stripFrm ? (egMask & egType_q) : 3'h0; // RULE7

  logic        fwdValid_q;
  logic [11:0] fwdVid_q;
  logic [2:0]  fwdPri_q;
  logic        fwdDrop_q;
  logic [2:0]  fwdEgressMask_q;
  logic [2:0]  fwdUntagMask_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwdValid_q      <= 1'b0;
      fwdVid_q        <= 12'h0;
      fwdPri_q        <= 3'h0;
      fwdDrop_q       <= 1'b0;
      fwdEgressMask_q <= 3'h0;
      fwdUntagMask_q  <= 3'h0;
    end else begin
      fwdValid_q      <= s1Valid_q;
      fwdVid_q        <= s1Vid_q;
      fwdPri_q        <= s1Pri_q;
      fwdDrop_q       <= s1Valid_q && dropFrm;
      fwdEgressMask_q <= s1Valid_q ? egMask : 3'h0;
      fwdUntagMask_q  <= s1Valid_q ? untagMask : 3'h0;
    end
  end

  assign fwdValid      = fwdValid_q;
  assign fwdVid        = fwdVid_q;
  assign fwdPri        = fwdPri_q;
  assign fwdDrop       = fwdDrop_q;
  assign fwdEgressMask = fwdEgressMask_q;
  assign fwdUntagMask  = fwdUntagMask_q;

endmodule : vtr_vlan_table_read_data

// ### dv/vtr_vlan_table_read_data_sva.sv
// Bind-in checker for the VLAN table reader ports
`timescale 1ns/1ps
`include "vtr_consts.svh"
module vtr_vlan_table_read_data_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        frmValid,
  input wire logic [1:0]  frmPort,
  input wire logic        frmTagged,
  input wire logic [11:0] frmVid,
  input wire logic        fwdValid,
  input wire logic [11:0] fwdVid,
  input wire logic        fwdDrop,
  input wire logic [2:0]  fwdEgressMask,
  input wire logic [2:0]  fwdUntagMask
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence rdTaken(idx);
    hsel && htrans[1] && hready && !hwrite && haddr[31:2] == idx;
  endsequence
  sequence goodFrame;
    frmValid && frmTagged && frmVid != 12'h000 && frmPort != 2'h3;
  endsequence

  rdval_upper_zero_a: assert property (
    rdTaken(`VTR_IDX_RDVAL) |=> hrdata[31:18] == 14'h0000)
    else $error("read data upper bits set");
  rdata_hold_a: assert property (
    !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  reset_clean_a: assert property (
    $rose(rst_n) |-> hrdata == 32'h0 && !fwdValid)
    else $error("outputs not clear after reset");
  fwd_latency_a: assert property (
    frmValid |-> ##2 fwdValid)
    else $error("frame result missing");
  fwd_origin_a: assert property (
    fwdValid |-> $past(frmValid, 2))
    else $error("frame result without request");
  tagged_vid_a: assert property (
    goodFrame |-> ##2 fwdVid == $past(frmVid, 2))
    else $error("tagged frame lost its VID");
  bad_port_a: assert property (
    frmValid && frmPort == 2'h3 |-> ##2 fwdValid && fwdDrop)
    else $error("frame from invalid port kept");
  member_pass_a: assert property (
    fwdValid && ((fwdEgressMask >> $past(frmPort, 2)) & 3'h1) != 3'h0
      |-> !fwdDrop)
    else $error("member frame dropped");
  untag_subset_a: assert property (
    fwdValid |-> (fwdUntagMask & ~fwdEgressMask) == 3'h0)
    else $error("untag outside egress ports");
endmodule : vtr_vlan_table_read_data_sva

bind vtr_vlan_table_read_data vtr_vlan_table_read_data_sva
  u_vtr_vlan_table_read_data_sva (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .frmValid(frmValid),
  .frmPort(frmPort), .frmTagged(frmTagged), .frmVid(frmVid),
  .fwdValid(fwdValid), .fwdVid(fwdVid), .fwdDrop(fwdDrop),
  .fwdEgressMask(fwdEgressMask), .fwdUntagMask(fwdUntagMask)
);

// ### dv/vtr_vlan_table_read_data_tb_top.sv
// Self-checking bench for the VLAN table reader
`timescale 1ns/1ps
`include "vtr_consts.svh"
module vtr_vlan_table_read_data_tb_top;
  logic        clk, rst_n, hsel, hwrite, hready, frmValid, frmTagged;
  logic        hreadyout, hresp, fwdValid, fwdDrop;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, frmPort;
  logic [2:0]  hsize, frmPri, fwdPri, fwdEgressMask, fwdUntagMask;
  logic [2:0]  admit, hyb;
  logic [11:0] frmVid, fwdVid;
  logic [15:0] lfsr = 16'h0033;
  logic        rdPh = 1'b0;
  logic [31:0] rdQ[$];
  logic [22:0] fwQ[$];
  logic [17:0] ent[16];
  logic [14:0] pdef[3];
  int          numErrors, nChecks;

  // One slave only, so its ready is the bus ready
  assign hready = hreadyout;

  vtr_vlan_table_read_data u_vtr_vlan_table_read_data (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frmValid(frmValid), .frmPort(frmPort), .frmTagged(frmTagged),
    .frmVid(frmVid), .frmPri(frmPri), .fwdValid(fwdValid), .fwdVid(fwdVid),
    .fwdPri(fwdPri), .fwdDrop(fwdDrop), .fwdEgressMask(fwdEgressMask),
    .fwdUntagMask(fwdUntagMask)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : completeRun

  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    // Judge by the ready seen last, so a late ready on the final try passes
    if (hready !== 1'b1) begin
      numErrors++;
      completeRun();
    end
  endtask : waitRdy

  task automatic bus(logic w, logic [29:0] ix, logic [31:0] wd,
                     logic [31:0] e);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {ix, 2'b00};
    if (!w)
      rdQ.push_back(e);
    waitRdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    waitRdy();
  endtask : bus

  // Pending clears two edges after the command write lands
  task automatic cmd(logic r, logic s, logic [4:0] ix);
    bus(1'b1, `VTR_IDX_CMD, {25'h0, r, s, ix}, 32'h0);
    repeat (2) @(posedge clk);
    bus(1'b0, `VTR_IDX_STAT, 32'h0, 32'h0);
  endtask : cmd

  function automatic logic [22:0] expFrm(logic [1:0] p, logic t,
                                         logic [11:0] v, logic [2:0] pr);
    logic [11:0] ev;
    logic [2:0]  ep, eg, ut;
    logic [17:0] en;
    if (p == 2'h3)
      return 23'h400000;
    ev = (t && v != 12'h000) ? v : pdef[p][11:0];
    ep = (t && v != 12'h000) ? pr : pdef[p][14:12];
    en = '0;
    // Walk downwards so the lowest matching index wins
    for (int i = 15; i >= 0; i--)
      if (ev != 12'h000 && ent[i][11:0] == ev)
        en = ent[i];
    eg = {en[17], en[15], en[13]};
    ut = en[12 + 2 * p] ? (eg & hyb) : 3'h0;
    return {1'b0, ev, ep, !eg[p] && !admit[p], eg, ut};
  endfunction : expFrm

  task automatic frame(logic [1:0] p, logic t, logic [11:0] v,
                       logic [2:0] pr);
    @(posedge clk);
    frmValid <= 1'b1;
    {frmPort, frmTagged, frmVid, frmPri} <= {p, t, v, pr};
    fwQ.push_back(expFrm(p, t, v, pr));
  endtask : frame

  always @(posedge clk) begin
    logic [22:0] fe;
    if (rdPh && rdQ.size() > 0)
      check("read data", hrdata, rdQ.pop_front());
    if (rdPh)
      check("read resp", {31'h0, hresp}, 32'h0);
    rdPh <= rst_n && hsel && htrans[1] && hready && !hwrite;
    // A result or an unknown valid with no request behind it is a fault
    if (fwdValid !== 1'b0 && fwQ.size() == 0)
      check("frame note", {31'h0, fwdValid}, 32'h0);
    if (fwdValid !== 1'b0 && fwQ.size() > 0) begin
      fe = fwQ.pop_front();
      if (fe[22])
        check("drop", {31'h0, fwdDrop}, 32'h1);
      else
        check("frame", {10'h0, fwdVid, fwdPri, fwdDrop, fwdEgressMask,
              fwdUntagMask}, {10'h0, fe[21:0]});
    end
  end

  initial begin
    rst_n = 1'b0;
    hsize = 3'h2;
    {hsel, hwrite, frmValid, frmTagged, admit, hyb} = '0;
    {haddr, hwdata, htrans, frmPort, frmVid, frmPri} = '0;
    ent = '{default: '0};
    pdef = '{default: '0};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `VTR_IDX_RDVAL, 32'h0, 32'h0);
    bus(1'b1, `VTR_IDX_RDVAL, 32'hffffffff, 32'h0);
    bus(1'b0, `VTR_IDX_RDVAL, 32'h0, 32'h0);
    bus(1'b0, 30'h00001000, 32'h0, 32'h0);
    for (int p = 0; p < 4; p++) begin
      cmd(1'b1, 1'b1, p[4:0]);
      bus(1'b0, `VTR_IDX_RDVAL, 32'h0, 32'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      d = {rnd(), rnd()};
      // Entry 3 stays disabled with the null VID
      d[11:0] = (i == 3) ? 12'h000 : {d[11:4] | 8'h01, i[3:0]};
      ent[i] = d[17:0];
      bus(1'b1, `VTR_IDX_WRVAL, d, 32'h0);
      cmd(1'b0, 1'b0, i[4:0]);
      cmd(1'b1, 1'b0, i[4:0]);
      bus(1'b0, `VTR_IDX_RDVAL, 32'h0, {14'h0, ent[i]});
    end
    for (int p = 0; p < 2; p++) begin
      d = {rnd(), rnd()};
      d[11:0] = ent[p * 5][11:0];
      pdef[p] = d[14:0];
      bus(1'b1, `VTR_IDX_WRVAL, d, 32'h0);
      cmd(1'b0, 1'b1, p[4:0]);
      cmd(1'b1, 1'b1, p[4:0]);
      bus(1'b0, `VTR_IDX_RDVAL, 32'h0, {17'h0, pdef[p]});
    end
    cmd(1'b0, 1'b0, 5'h10);
    bus(1'b0, `VTR_IDX_RDVAL, 32'h0, {17'h0, pdef[1]});
    $display("test table access done");
    for (int r = 0; r < 2; r++) begin
      d = {rnd(), rnd()};
      admit = d[2:0] & {3{r[0]}};
      hyb = d[5:3];
      bus(1'b1, `VTR_IDX_ADMIT, {29'h0, admit}, 32'h0);
      bus(1'b1, `VTR_IDX_EGTYPE, {29'h0, hyb}, 32'h0);
      for (int k = 0; k < 64; k++) begin
        d = {rnd(), rnd()};
        frame(d[1:0], d[2], d[3] ? ent[d[7:4]][11:0] : d[15:4], d[18:16]);
      end
      @(posedge clk);
      frmValid <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("test frame classing done");
    rst_n <= 1'b0;
    ent = '{default: '0};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `VTR_IDX_RDVAL, 32'h0, 32'h0);
    cmd(1'b1, 1'b0, 5'h01);
    bus(1'b0, `VTR_IDX_RDVAL, 32'h0, 32'h0);
    $display("test second reset done");
    repeat (3) @(posedge clk);
    check("notes left", rdQ.size() + fwQ.size(), 32'h0);
    completeRun();
  end
endmodule : vtr_vlan_table_read_data_tb_top
